// ### hdl/oms_pkg.sv
package oms_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int LANES = 4;
    localparam int DW = 8;
    localparam int AW = 7;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------------
    // Register map of the serial link, one byte per address
    // ------------------------------------------------------------------
    localparam logic [AW-1:0] ADDR_STATUS = 7'h00;
    localparam logic [AW-1:0] ADDR_CONTROL = 7'h01;
    localparam logic [AW-1:0] ADDR_LOS = 7'h02;
    localparam logic [AW-1:0] ADDR_POWER0 = 7'h03;
    localparam int STAT_NOT_READY_BIT = 0;
    localparam int STAT_RESET_DONE_BIT = 1;
    localparam int STAT_LOS_BIT = 2;
    localparam logic [DW-1:0] CTRL_RESET = 8'h00;
    localparam logic [DW-1:0] UNMAPPED_VALUE = 8'h00;

    // ------------------------------------------------------------------
    // Frame layout in link clock edges
    // ------------------------------------------------------------------
    localparam logic [4:0] EDGE_CMD_LAST = 5'h07;
    localparam logic [4:0] EDGE_WR_LAST = 5'h0F;
    localparam logic [4:0] EDGE_RD_LOAD = 5'h0A;
    localparam logic [4:0] EDGE_RD_LAST = 5'h12;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int RESET_MIN_NS = 10000;
    localparam int INIT_TIME_NS = 2000;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int INIT_CYC = (INIT_TIME_NS * CLK_MHZ + 999) / 1000;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic out;
        logic oe;
    } oms_od_t;

    typedef struct packed {
        logic rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
    } oms_req_t;

endpackage

// ### hdl/oms_link.sv
`timescale 1ns/10ps
module oms_link (
    // Link clock and reset
    input wire logic scl_clk,
    input wire logic rst_n,
    // Link pins
    input wire logic module_select_n,
    input wire logic sda_in,
    output oms_pkg::oms_od_t sda_od,
    // Crossing to the register side
    output logic req_tgl,
    output oms_pkg::oms_req_t req,
    input wire logic ack_tgl,
    input wire logic [oms_pkg::DW-1:0] rd_data
);

    logic rs1_q, rs2_q, a1_q, a2_q;
    logic link_rst_n;
    logic [4:0] cnt_q;
    logic [14:0] shift_q;
    logic [oms_pkg::DW-1:0] out_q;
    logic drive_q, rd_q, req_tgl_q;
    oms_pkg::oms_req_t req_q;
    logic [oms_pkg::DW-1:0] byte_now;

    // Reset and answer toggle synchronisers; first stages feed only second.
    always_ff @(posedge scl_clk) begin
        rs1_q <= rst_n;
        rs2_q <= rs1_q;
        a1_q <= ack_tgl;
        a2_q <= a1_q;
    end
    assign link_rst_n = rs2_q;
    assign byte_now = {shift_q[6:0], sda_in};

    // Bit counter; a deselected edge restarts the frame.
    always_ff @(posedge scl_clk) begin
        if (!link_rst_n || module_select_n) begin
            cnt_q <= 5'h00;
        end else if ((!rd_q && cnt_q == oms_pkg::EDGE_WR_LAST && cnt_q != 5'h00) ||
                     (rd_q && cnt_q == oms_pkg::EDGE_RD_LAST)) begin
            cnt_q <= 5'h00;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end

    // Shift in bits and raise a request once a read command or a write data byte is whole.
    always_ff @(posedge scl_clk) begin
        if (!link_rst_n) begin
            shift_q <= 15'h0000;
            rd_q <= 1'b0;
            req_tgl_q <= 1'b0;
            req_q <= '0;
        end else if (!module_select_n) begin
            shift_q <= {shift_q[13:0], sda_in};
            if (cnt_q == oms_pkg::EDGE_CMD_LAST) begin
                rd_q <= byte_now[7];
                req_q.rd <= byte_now[7];
                req_q.addr <= byte_now[6:0];
                if (byte_now[7]) begin
                    req_tgl_q <= ~req_tgl_q;
                end
            end else if (!rd_q && cnt_q == oms_pkg::EDGE_WR_LAST) begin
                req_q.data <= byte_now;
                req_tgl_q <= ~req_tgl_q;
            end
        end
    end

    // Read data is loaded two edges after the answer toggle had time to settle.
    // The host samples each bit on the edge after it is put out.
    always_ff @(posedge scl_clk) begin
        if (!link_rst_n || module_select_n) begin
            drive_q <= 1'b0;
            out_q <= oms_pkg::UNMAPPED_VALUE;
        end else if (rd_q && cnt_q == oms_pkg::EDGE_RD_LOAD) begin
            drive_q <= 1'b1;
            out_q <= rd_data;
        end else if (cnt_q == oms_pkg::EDGE_RD_LAST) begin
            drive_q <= 1'b0;
        end else begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    assign sda_od.out = 1'b0;
    assign sda_od.oe = drive_q & ~out_q[7];
    assign req_tgl = req_tgl_q;
    assign req = req_q;

    a_sda_idle_unsel: assert property (@(posedge scl_clk) disable iff (!link_rst_n)
        module_select_n |=> !sda_od.oe) else $error("Link drives data while deselected.");

    a_cmd_read_req: assert property (@(posedge scl_clk) disable iff (!link_rst_n)
        (!module_select_n && cnt_q == 5'h07 && shift_q[6]) |=> (req_tgl != $past(req_tgl)))
        else $error("Selected read command raised no request.");

endmodule // oms_link

// ### hdl/oms_sideband.sv
`timescale 1ns/10ps
// Function
// - While selected, the module answers commands on the two-wire link.
// - A reset pin held low past the minimum fully resets all settings.
// - Reset completion raises the interrupt with the not-ready bit cleared.
// - Power-up raises the completion interrupt without any reset pulse.
// - The interrupt output goes low for faults or critical status.
// - Loss of light is raised when any lane falls below threshold.
// - The laser turns off on the hardware request or a link command.
// - Received power of each lane is readable over the link.
// - The low power select input caps maximum power consumption.
// - The module pulls the presence signal low once inserted.
module oms_sideband #(
    parameter int RESET_MIN = oms_pkg::RESET_MIN_CYC,
    parameter int INIT_LEN = oms_pkg::INIT_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Two-wire link
    input wire logic scl_clk,
    input wire logic module_select_n,
    input wire logic sda_in,
    output oms_pkg::oms_od_t sda_od,
    // Host control pins
    input wire logic module_reset_n,
    input wire logic low_power_select,
    input wire logic laser_off_request,
    output oms_pkg::oms_od_t interrupt_n_od,
    output oms_pkg::oms_od_t module_present_n_od,
    // Optics side
    input wire logic [oms_pkg::LANES-1:0] lane_dark,
    input wire logic [oms_pkg::LANES*oms_pkg::DW-1:0] rx_power,
    output logic [oms_pkg::LANES-1:0] laser_output_off,
    output logic receive_light_lost,
    output logic power_cap,
    output logic data_not_ready
);

    typedef enum logic [2:0] {
        ST_INIT = 3'b001,
        ST_READY = 3'b010,
        ST_HELD = 3'b100
    } oms_state_t;

    localparam int SW = 3 + oms_pkg::LANES;

    oms_state_t state_q;
    logic [SW-1:0] s1_q, s2_q;
    logic pin_rst_s, lp_s, hw_off_s;
    logic [oms_pkg::LANES-1:0] dark_s;
    logic t1_q, t2_q, t3_q, req_new, ack_tgl_q;
    logic req_tgl;
    oms_pkg::oms_req_t req;
    logic [oms_pkg::CNT_W-1:0] pin_low_cnt_q, init_cnt_q;
    logic [oms_pkg::DW-1:0] ctrl_q, rd_data_q, rd_mux;
    logic reset_done_q, int_q;
    logic [oms_pkg::LANES-1:0] los_flag_q;
    logic clr_done, clr_los;
    logic [oms_pkg::LANES-1:0] off_q;
    logic los_q, cap_q, dnr_q;

    // ------------------------------------------------------------------
    // Link logic on its own clock
    // ------------------------------------------------------------------
    oms_link u_link (
        .scl_clk(scl_clk),
        .rst_n(rst_n),
        .module_select_n(module_select_n),
        .sda_in(sda_in),
        .sda_od(sda_od),
        .req_tgl(req_tgl),
        .req(req),
        .ack_tgl(ack_tgl_q),
        .rd_data(rd_data_q)
    );

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Pins and the request toggle pass two flops; the third toggle flop is for edges.
    always_ff @(posedge ref_clk) begin
        s1_q <= {module_reset_n, low_power_select, laser_off_request, lane_dark};
        s2_q <= s1_q;
        t1_q <= req_tgl;
        t2_q <= t1_q;
        t3_q <= t2_q;
    end
    assign pin_rst_s = ~s2_q[SW-1];
    assign lp_s = s2_q[SW-2];
    assign hw_off_s = s2_q[SW-3];
    assign dark_s = s2_q[oms_pkg::LANES-1:0];
    assign req_new = t2_q ^ t3_q;

    // ------------------------------------------------------------------
    // Reset sequencing
    // ------------------------------------------------------------------
    // The pin must stay low past the minimum, so short glitches never reset.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || !pin_rst_s) begin
            pin_low_cnt_q <= '0;
        end else if (pin_low_cnt_q != oms_pkg::CNT_W'(RESET_MIN)) begin
            pin_low_cnt_q <= pin_low_cnt_q + 1'b1;
        end
    end

    // Power-up and pin reset both pass through the init phase before ready.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_q <= ST_INIT;
            init_cnt_q <= '0;
        end else if (pin_rst_s && pin_low_cnt_q == oms_pkg::CNT_W'(RESET_MIN)) begin
            state_q <= ST_HELD;
            init_cnt_q <= '0;
        end else begin
            case (state_q)
                ST_INIT: begin
                    init_cnt_q <= init_cnt_q + 1'b1;
                    if (init_cnt_q == oms_pkg::CNT_W'(INIT_LEN - 1)) begin
                        state_q <= ST_READY;
                    end
                end
                ST_READY: begin
                    state_q <= ST_READY;
                end
                ST_HELD: begin
                    if (!pin_rst_s) begin
                        state_q <= ST_INIT;
                    end
                end
                default: begin
                    state_q <= ST_INIT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Register side of the link
    // ------------------------------------------------------------------
    // Read mux; the monitored lane power is live, not latched.
    always_comb begin
        rd_mux = oms_pkg::UNMAPPED_VALUE;
        if (req.addr == oms_pkg::ADDR_STATUS) begin
            rd_mux[oms_pkg::STAT_NOT_READY_BIT] = dnr_q;
            rd_mux[oms_pkg::STAT_RESET_DONE_BIT] = reset_done_q;
            rd_mux[oms_pkg::STAT_LOS_BIT] = |los_flag_q;
        end else if (req.addr == oms_pkg::ADDR_CONTROL) begin
            rd_mux = ctrl_q;
        end else if (req.addr == oms_pkg::ADDR_LOS) begin
            rd_mux[oms_pkg::LANES-1:0] = los_flag_q;
        end
        for (int i = 0; i < oms_pkg::LANES; i++) begin
            if (req.addr == oms_pkg::ADDR_POWER0 + oms_pkg::AW'(i)) begin
                rd_mux = rx_power[i*oms_pkg::DW +: oms_pkg::DW];
            end
        end
    end

    assign clr_done = req_new && req.rd && req.addr == oms_pkg::ADDR_STATUS;
    assign clr_los = req_new && req.rd && req.addr == oms_pkg::ADDR_LOS;

    // Read data is held until the next request, so the link side may sample it late.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data_q <= oms_pkg::UNMAPPED_VALUE;
            ack_tgl_q <= 1'b0;
        end else if (req_new && req.rd) begin
            rd_data_q <= rd_mux;
            ack_tgl_q <= ~ack_tgl_q;
        end
    end

    // Control byte; low lanes disable each laser. Cleared by any full reset.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || state_q == ST_HELD) begin
            ctrl_q <= oms_pkg::CTRL_RESET;
        end else if (req_new && !req.rd && req.addr == oms_pkg::ADDR_CONTROL) begin
            ctrl_q <= req.data;
        end
    end

    // Sticky flags; a new event wins over a read clear in the same cycle.
    always_ff @(posedge ref_clk) begin
        if (!rst_n || state_q == ST_HELD) begin
            reset_done_q <= 1'b0;
            los_flag_q <= '0;
        end else begin
            if (state_q == ST_INIT && init_cnt_q == oms_pkg::CNT_W'(INIT_LEN - 1)) begin
                reset_done_q <= 1'b1;
            end else if (clr_done) begin
                reset_done_q <= 1'b0;
            end
            los_flag_q <= dark_s | (clr_los ? '0 : los_flag_q);
        end
    end

    // ------------------------------------------------------------------
    // Pin outputs
    // ------------------------------------------------------------------
    // Outputs are registered so the pins never see decode glitches.
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            int_q <= 1'b0;
            off_q <= '1;
            los_q <= 1'b0;
            cap_q <= 1'b1;
            dnr_q <= 1'b1;
        end else begin
            int_q <= (state_q == ST_READY) && (reset_done_q || |los_flag_q);
            off_q <= {oms_pkg::LANES{hw_off_s}} | ctrl_q[oms_pkg::LANES-1:0];
            los_q <= |dark_s;
            cap_q <= lp_s;
            dnr_q <= state_q != ST_READY;
        end
    end

    assign interrupt_n_od.out = 1'b0;
    assign interrupt_n_od.oe = int_q;
    assign module_present_n_od.out = 1'b0;
    assign module_present_n_od.oe = 1'b1;
    assign laser_output_off = off_q;
    assign receive_light_lost = los_q;
    assign power_cap = cap_q;
    assign data_not_ready = dnr_q;

    a_present_low: assert property (@(posedge ref_clk) disable iff (!rst_n)
        module_present_n_od.oe && !module_present_n_od.out)
        else $error("Presence is not pulled low.");

    a_laser_hw_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
        hw_off_s |=> &laser_output_off) else $error("Laser not off on request.");

    a_los_alarm: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (|dark_s && state_q != ST_HELD) |=> receive_light_lost ##0 los_flag_q != '0)
        else $error("Dark lane raised no alarm.");

    a_power_cap: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $changed(lp_s) |=> power_cap == $past(lp_s)) else $error("Power cap does not follow.");

    a_reset_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(state_q == ST_HELD) |-> $past(pin_low_cnt_q) == oms_pkg::CNT_W'(RESET_MIN)
        ##1 ctrl_q == oms_pkg::CTRL_RESET) else $error("Pin reset wrong.");

    a_done_intr: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (state_q == ST_INIT && init_cnt_q == oms_pkg::CNT_W'(INIT_LEN - 1) &&
         !pin_rst_s) |=> ##1 (interrupt_n_od.oe && !data_not_ready))
        else $error("Reset completion not signalled.");

    a_intr_held: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(interrupt_n_od.oe) |-> ($past(req_new, 2) || $past(state_q != ST_READY)))
        else $error("Interrupt dropped without a read.");

    a_power_read: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (req_new && req.rd && req.addr == oms_pkg::ADDR_POWER0) |=>
        rd_data_q == $past(rx_power[oms_pkg::DW-1:0])) else $error("Lane power misread.");

endmodule // oms_sideband

// ### dv/oms_host_model.sv
`timescale 1ns/10ps
// Host side of the link; the link clock runs only while the host talks.
module oms_host_model (
    // Link pins
    output logic scl_clk,
    output logic module_select_n,
    output wire logic sda_in,
    input oms_pkg::oms_od_t sda_od
);
    // ----------------
    // Wire and state
    // ----------------
    localparam realtime HALF = 62.5;
    logic host_pull;
    logic seen;

    // Open-drain data line with a pull-up; either party may pull it low.
    assign sda_in = !(host_pull || (sda_od.oe && !sda_od.out));

    initial begin
        scl_clk = 1'b0;
        module_select_n = 1'b1;
        host_pull = 1'b0;
    end

    // ----------------
    // Link tasks
    // ----------------
    // One clock pulse; the line is sampled just before the rising edge.
    task automatic pulse();
        #(HALF);
        seen = sda_in;
        scl_clk = 1'b1;
        #(HALF);
        scl_clk = 1'b0;
    endtask

    // Pulses with the module deselected, as when other modules are addressed.
    task automatic idle(input int n);
        module_select_n = 1'b1;
        repeat (n) pulse();
    endtask

    // One whole frame; a deselected edge follows so the next frame starts clean.
    task automatic frame(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
        input logic sel_n, output logic [7:0] rdata);
        logic [15:0] word;
        word = {rd, addr, wdata};
        rdata = 8'h00;
        module_select_n = sel_n;
        for (int i = 0; i < (rd ? 19 : 16); i++) begin
            host_pull = (rd && i >= 8) ? 1'b0 : !word[15 - i];
            pulse();
            if (rd && i >= 11) begin
                rdata = {rdata[6:0], seen};
            end
        end
        host_pull = 1'b0;
        idle(1);
    endtask
endmodule // oms_host_model

// ### dv/test_optical_module_sideband_control.sv
`timescale 1ns/10ps
module test_optical_module_sideband_control;
    // ----------------
    // Signals
    // ----------------
    localparam int RMIN = 8;
    localparam int ILEN = 4;
    logic ref_clk, rst_n, module_reset_n, low_power_select, laser_off_request;
    logic scl_clk, module_select_n, sda_in;
    logic [3:0] lane_dark, laser_output_off;
    logic [31:0] rx_power;
    logic receive_light_lost, power_cap, data_not_ready;
    logic [7:0] rd;
    oms_pkg::oms_od_t sda_od, interrupt_n_od, module_present_n_od;
    int fails, checks_done, cycles;

    oms_sideband #(.RESET_MIN(RMIN), .INIT_LEN(ILEN)) uut (.ref_clk(ref_clk), .rst_n(rst_n),
        .scl_clk(scl_clk), .module_select_n(module_select_n), .sda_in(sda_in),
        .sda_od(sda_od), .module_reset_n(module_reset_n), .low_power_select(low_power_select),
        .laser_off_request(laser_off_request), .interrupt_n_od(interrupt_n_od),
        .module_present_n_od(module_present_n_od), .lane_dark(lane_dark), .rx_power(rx_power),
        .laser_output_off(laser_output_off), .receive_light_lost(receive_light_lost),
        .power_cap(power_cap), .data_not_ready(data_not_ready));

    oms_host_model host (.scl_clk(scl_clk), .module_select_n(module_select_n),
        .sda_in(sda_in), .sda_od(sda_od));

    // ----------------
    // Clock and helpers
    // ----------------
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    // A hung handshake ends here; the run needs about 4300 cycles.
    always @(posedge ref_clk) begin
        cycles = cycles + 1;
        if (cycles == 20000) begin
            fails = fails + 1;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // The flag is allowed a bounded number of cycles to reach its level.
    task automatic wait_int(input logic lvl, input string what);
        int n;
        n = 0;
        while (interrupt_n_od.oe !== lvl && n < 40) begin
            wait_cyc(1);
            n++;
        end
        check(interrupt_n_od.oe, lvl, what);
    endtask

    task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp, input string what);
        host.frame(1'b1, a, 8'h00, 1'b0, rd);
        wait_cyc(1);
        check(rd, exp, what);
    endtask

    task automatic wr_reg(input logic [6:0] a, input logic [7:0] v);
        host.frame(1'b0, a, v, 1'b0, rd);
        wait_cyc(8);
    endtask

    // ----------------
    // Main sequence
    // ----------------
    initial begin
        rst_n = 1'b0;
        module_reset_n = 1'b1;
        low_power_select = 1'b1;
        laser_off_request = 1'b0;
        lane_dark = 4'h0;
        rx_power = 32'hA1B2C3D4;
        fails = 0;
        checks_done = 0;
        cycles = 0;
        // The link side takes reset on its own clock, so link edges must pass while held.
        fork
            wait_cyc(20);
            host.idle(3);
        join
        wait_cyc(1);
        check(module_present_n_od.oe, 1'b1, "presence");
        check(laser_output_off, 4'hF, "laser in reset");
        rst_n = 1'b1;
        host.idle(4);
        // Power-up completion with no pin pulse; status is read only after it.
        wait_int(1'b1, "power-up interrupt");
        check(data_not_ready, 1'b0, "not ready after init");
        rd_reg(oms_pkg::ADDR_STATUS, 8'h02, "status after power-up");
        wait_int(1'b0, "interrupt after read");
        rd_reg(oms_pkg::ADDR_STATUS, 8'h00, "done flag cleared");
        for (int i = 0; i < 2; i++) begin
            low_power_select = i[0];
            wait_cyc(4);
            check(power_cap, i[0], "power cap");
        end
        // Laser off from a link command and from the hardware request.
        wr_reg(oms_pkg::ADDR_CONTROL, 8'h05);
        check(laser_output_off, 4'h5, "link laser off");
        laser_off_request = 1'b1;
        wait_cyc(4);
        check(laser_output_off, 4'hF, "hardware laser off");
        laser_off_request = 1'b0;
        wait_cyc(4);
        rd_reg(oms_pkg::ADDR_CONTROL, 8'h05, "control readback");
        // Deselected traffic is ignored and the line stays released.
        host.frame(1'b0, oms_pkg::ADDR_CONTROL, 8'h0F, 1'b1, rd);
        wait_cyc(8);
        check(laser_output_off, 4'h5, "deselected write");
        host.frame(1'b1, oms_pkg::ADDR_CONTROL, 8'h00, 1'b1, rd);
        check(rd, 8'hFF, "deselected read");
        // Loss of light on one lane is latched until its flag is read.
        lane_dark = 4'h4;
        wait_cyc(6);
        check(receive_light_lost, 1'b1, "loss of light");
        wait_int(1'b1, "loss interrupt");
        lane_dark = 4'h0;
        wait_cyc(6);
        check(receive_light_lost, 1'b0, "light back");
        rd_reg(oms_pkg::ADDR_STATUS, 8'h04, "status source");
        check(interrupt_n_od.oe, 1'b1, "held until flag read");
        rd_reg(oms_pkg::ADDR_LOS, 8'h04, "lane flags");
        wait_int(1'b0, "loss interrupt cleared");
        rd_reg(oms_pkg::ADDR_LOS, 8'h00, "lane flags cleared");
        for (int i = 0; i < 4; i++) begin
            rd_reg(oms_pkg::ADDR_POWER0 + 7'(i), rx_power[8*i +: 8], "power");
        end
        rd_reg(7'h40, oms_pkg::UNMAPPED_VALUE, "unmapped");
        // A short pin pulse is ignored; a long one restores the defaults.
        wr_reg(oms_pkg::ADDR_CONTROL, 8'h03);
        module_reset_n = 1'b0;
        wait_cyc(3);
        module_reset_n = 1'b1;
        wait_cyc(10);
        check(laser_output_off, 4'h3, "short pulse");
        module_reset_n = 1'b0;
        wait_cyc(RMIN + 6);
        check(data_not_ready, 1'b1, "held in reset");
        module_reset_n = 1'b1;
        wait_int(1'b1, "reset completion");
        check(laser_output_off, 4'h0, "defaults");
        rd_reg(oms_pkg::ADDR_STATUS, 8'h02, "completion status");
        rd_reg(oms_pkg::ADDR_CONTROL, oms_pkg::CTRL_RESET, "control default");
        print_verdict();
    end
endmodule // test_optical_module_sideband_control
